/* bench/cmosit_can_node.sv */
// far node on the shared bus: wired-and of our drive and its own level
// assumes the bench sets the far node level; recessive is 1
`timescale 1ns/1ps
`default_nettype none
module cmosit_can_node (
  // our side
  input wire logic ourBit,
  input wire logic ourDrive,
  // far node
  input wire logic nodeLevel,
  // shared line
  output logic busLevel
);
  // dominant wins; undriven line returns to recessive by the pull-up
  assign busLevel = nodeLevel & (ourDrive ? ourBit : 1'b1);
endmodule
`default_nettype wire

/* bench/cmosit_msg_obj_sva.sv */
// assertions on the register, event and interrupt ports of the message object block
// bound to cmosit_msg_obj from the testbench top file; one clock domain
`timescale 1ns/1ps
`default_nettype none
module cmosit_msg_obj_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register bus
  input wire cmosit_pkg::cmosit_sfr_type sfr,
  input wire logic [7:0] sfrRdData,
  // bus and sequencer
  input wire logic canRxPin,
  input wire logic bitTick,
  input wire cmosit_pkg::cmosit_field_type field,
  input wire cmosit_pkg::cmosit_evt_type evt,
  // watched outputs
  input wire logic rxBitSync,
  input wire logic txReq,
  input wire logic [3:0] rxTarget,
  input wire logic [cmosit_pkg::OBJ_COUNT-1:0] objIrq
);
  logic [7:0] pageByte;
  logic [1:0] upCnt;
  logic [3:0] lowHit;
  logic [3:0] obj;
  logic mapped;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  assign obj = pageByte[7:4];
  assign mapped = sfr.addr inside {[8'hb1:8'hb3], [8'hbc:8'hbf]};
  always_comb begin
    lowHit = 4'h0;
    for (int i = cmosit_pkg::OBJ_COUNT - 1; i >= 0; i--) begin
      if (evt.rxHit[i]) begin
        lowHit = 4'(i);
      end
    end
  end
  // page copy kept here so checks need no view of the bodies
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pageByte <= 8'h00;
    end else if (sfr.wrEn && sfr.addr == cmosit_pkg::ADDR_PAGE) begin
      pageByte <= sfr.wrData;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      upCnt <= 2'h0;
    end else if (upCnt != 2'h3) begin
      upCnt <= upCnt + 2'h1;
    end
  end
  rd_data_hold_a: assert property (!sfr.rdEn |=> $stable(sfrRdData))
    else $error("read data changed without a read");
  page_read_a: assert property (sfr.rdEn && !sfr.wrEn && sfr.addr == cmosit_pkg::ADDR_PAGE
    |=> sfrRdData == $past(pageByte)) else $error("page read mismatch");
  zero_read_a: assert property (sfr.rdEn && (!mapped || (obj == 4'hf && sfr.addr != cmosit_pkg::ADDR_PAGE))
    |=> sfrRdData == 8'h00) else $error("empty read not zero");
  sync_delay_a: assert property (upCnt == 2'h3 |-> rxBitSync == $past(canRxPin, 2))
    else $error("bus level sync delay wrong");
  txreq_conf_a: assert property (sfr.wrEn && sfr.addr == cmosit_pkg::ADDR_CTRL && obj != 4'hf
    && sfr.wrData[7:6] == cmosit_pkg::CONF_TX && !evt.txDone |=> ##1 txReq) else $error("launch gave no request");
  clear_irq_a: assert property (sfr.wrEn && sfr.addr == cmosit_pkg::ADDR_STATUS && sfr.wrData == 8'h00
    && obj != 4'hf && !evt.txDone && !evt.rxDone && !$past(bitTick) |=> ##1 !objIrq[obj])
    else $error("interrupt survived status clear");
  rx_target_a: assert property (evt.rxHit != 0 |=> rxTarget == $past(lowHit))
    else $error("receive target not lowest hit");
  rx_irq_a: assert property (evt.rxDone && evt.rxHit != 0 |=> ##1 objIrq[$past(lowHit, 2)])
    else $error("receive gave no interrupt");
  form_irq_a: assert property (bitTick && field.crcDelim && !field.txActive && !rxBitSync
    |-> ##3 objIrq[$past(rxTarget, 3)]) else $error("form error gave no interrupt");
  rx_hit_c: cover property (evt.rxDone && evt.rxHit != 0);
  tx_launch_c: cover property ($rose(txReq));
  err_tick_c: cover property (bitTick && field.crcDelim);
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for message object status flags and identifier tags
// assumes cmosit_msg_obj, the bus node model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [10:0] F_TXA = 11'h400;
  localparam logic [10:0] F_ARB = 11'h200;
  localparam logic [10:0] F_ACK = 11'h100;
  localparam logic [10:0] F_STF = 11'h040;
  localparam logic [10:0] F_CRR = 11'h020;
  localparam logic [10:0] F_CRF = 11'h010;
  localparam logic [10:0] F_CDL = 11'h008;
  localparam logic [10:0] F_ADL = 11'h004;
  localparam logic [10:0] F_EOF = 11'h002;
  localparam logic [10:0] F_SOF = 11'h001;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  cmosit_pkg::cmosit_sfr_type sfr = '0;
  cmosit_pkg::cmosit_field_type field = '0;
  cmosit_pkg::cmosit_evt_type evt = '0;
  logic bitTick = 1'b0;
  logic txBit = 1'b1;
  logic nodeLevel = 1'b1;
  logic canRxPin, rxBitSync, txReq, txIde, txRtr;
  logic [3:0] txObject, txDlc, rxTarget;
  logic [7:0] sfrRdData;
  logic [28:0] txIdentifier;
  logic [14:0] objIrq;
  logic [7:0] extTag [4] = '{8'hc3, 8'h5a, 8'h3c, 8'hf6};
  logic [7:0] stdTag [4] = '{8'hc3, 8'h40, 8'h00, 8'h04};
  int num_errors = 0;
  int n_checks = 0;
  int i, b;
  always #20 sys_clk = ~sys_clk;
  cmosit_can_node node (.ourBit(txBit), .ourDrive(field.txActive), .nodeLevel(nodeLevel), .busLevel(canRxPin));
  cmosit_msg_obj dut (.sys_clk(sys_clk), .rst_b(rst_b), .sfr(sfr), .sfrRdData(sfrRdData), .canRxPin(canRxPin),
    .bitTick(bitTick), .txBit(txBit), .field(field), .evt(evt), .rxBitSync(rxBitSync), .txReq(txReq),
    .txObject(txObject), .txIdentifier(txIdentifier), .txIde(txIde), .txRtr(txRtr), .txDlc(txDlc),
    .rxTarget(rxTarget), .objIrq(objIrq));
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [28:0] got, input logic [28:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr = '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(negedge sys_clk);
    sfr.wrEn = 1'b0;
  endtask
  // read strobe held across one rising edge; data taken once it has landed
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    sfr.addr = a;
    sfr.rdEn = 1'b1;
    @(negedge sys_clk);
    sfr.rdEn = 1'b0;
    chk(29'(sfrRdData), 29'(exp));
  endtask
  // two cycles for the rx synchroniser before the sample tick
  task automatic step(input logic lvl, input logic tx, input logic [10:0] f);
    @(negedge sys_clk);
    nodeLevel = lvl;
    txBit = tx;
    field = cmosit_pkg::cmosit_field_type'(f);
    repeat (2) @(negedge sys_clk);
    bitTick = 1'b1;
    @(negedge sys_clk);
    bitTick = 1'b0;
  endtask
  task automatic ev(input logic txd, input logic rxd, input logic [3:0] dlc, input logic [14:0] hit);
    @(negedge sys_clk);
    evt = '{txDone: txd, rxDone: rxd, rxDlc: dlc, rxHit: hit};
    @(negedge sys_clk);
    evt = '0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic stat(input logic [3:0] o, input logic [7:0] exp);
    wr(cmosit_pkg::ADDR_PAGE, {o, 4'h0});
    rdc(cmosit_pkg::ADDR_STATUS, exp);
    wr(cmosit_pkg::ADDR_STATUS, 8'h00);
  endtask
  task automatic waitTx;
    for (int k = 0; k < 8 && txReq !== 1'b1; k++) @(negedge sys_clk);
    if (txReq !== 1'b1) begin
      num_errors++;
      $display("FAIL t=%0t no transmit request", $time);
      end_sim;
    end
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("FAIL t=%0t run timed out", $time);
    end_sim;
  end
  initial begin
    repeat (6) @(negedge sys_clk);
    chk(29'({rxBitSync, txReq, objIrq}), 29'h10000);
    rst_b = 1'b1;
    rdc(cmosit_pkg::ADDR_PAGE, 8'h00);
    rdc(cmosit_pkg::ADDR_STATUS, 8'h00);
    rdc(cmosit_pkg::ADDR_CTRL, 8'h00);
    rdc(8'hb4, 8'h00);
    wr(cmosit_pkg::ADDR_PAGE, 8'h30);
    wr(cmosit_pkg::ADDR_CTRL, 8'h18);
    for (i = 0; i < 4; i++) wr(8'hbc + 8'(i), extTag[i]);
    for (i = 0; i < 4; i++) rdc(8'hbc + 8'(i), extTag[i]);
    wr(cmosit_pkg::ADDR_CTRL, 8'h58);
    waitTx;
    chk(29'({txObject, txIde, txRtr, txDlc}), 29'h0f8);
    chk(txIdentifier, {8'hc3, 8'h5a, 8'h3c, 5'h1e});
    wr(cmosit_pkg::ADDR_CTRL, 8'h48);
    for (i = 0; i < 4; i++) rdc(8'hbc + 8'(i), stdTag[i]);
    chk(29'({txObject, txIde, txRtr, txDlc}), 29'h0d8);
    chk(txIdentifier, 29'h61a);
    wr(cmosit_pkg::ADDR_PAGE, 8'h10);
    wr(cmosit_pkg::ADDR_CTRL, 8'h42);
    repeat (2) @(negedge sys_clk);
    chk(29'(txObject), 29'h1);
    step(1'b1, 1'b1, F_SOF | F_TXA);
    ev(1'b1, 1'b0, 4'h0, 15'h0);
    rdc(cmosit_pkg::ADDR_STATUS, 8'h40);
    chk(29'(objIrq), 29'h2);
    rdc(cmosit_pkg::ADDR_CTRL, 8'h02);
    chk(29'(txObject), 29'h3);
    wr(cmosit_pkg::ADDR_STATUS, 8'hff);
    rdc(cmosit_pkg::ADDR_STATUS, 8'h40);
    wr(cmosit_pkg::ADDR_STATUS, 8'h00);
    rdc(cmosit_pkg::ADDR_STATUS, 8'h00);
    chk(29'(objIrq), 29'h0);
    wr(cmosit_pkg::ADDR_PAGE, 8'h60);
    wr(cmosit_pkg::ADDR_CTRL, 8'h88);
    wr(cmosit_pkg::ADDR_PAGE, 8'h40);
    wr(cmosit_pkg::ADDR_CTRL, 8'h88);
    ev(1'b0, 1'b1, 4'h3, 15'h0050);
    chk(29'(rxTarget), 29'h4);
    rdc(cmosit_pkg::ADDR_CTRL, 8'h83);
    stat(4'h4, 8'ha0);
    stat(4'h6, 8'h00);
    ev(1'b0, 1'b1, 4'h3, 15'h0010);
    ev(1'b0, 1'b1, 4'h5, 15'h0);
    stat(4'h4, 8'h20);
    step(1'b0, 1'b1, F_CDL);
    repeat (2) @(negedge sys_clk);
    chk(29'(objIrq), 29'h10);
    stat(4'h4, 8'h02);
    step(1'b1, 1'b1, F_SOF | F_STF);
    for (i = 0; i < 6; i++) step(1'b0, 1'b1, F_STF);
    stat(4'h4, 8'h08);
    // a zero frame bit leaves the crc at zero, so one stray field bit must fail it
    for (b = 0; b < 2; b++) begin
      step(1'b0, 1'b1, F_SOF | F_CRR);
      for (i = 0; i < 15; i++) step(b == 1 && i == 7, 1'b1, F_CRF);
      step(1'b1, 1'b1, F_CDL);
      stat(4'h4, b == 1 ? 8'h04 : 8'h00);
    end
    step(1'b1, 1'b1, F_SOF | F_TXA);
    step(1'b0, 1'b1, F_TXA | F_ARB);
    step(1'b0, 1'b0, F_TXA);
    step(1'b0, 1'b1, F_TXA | F_ACK);
    stat(4'h3, 8'h00);
    step(1'b0, 1'b1, F_TXA);
    stat(4'h3, 8'h10);
    step(1'b1, 1'b1, F_TXA | F_ACK);
    stat(4'h3, 8'h01);
    step(1'b0, 1'b1, F_ADL);
    stat(4'h4, 8'h02);
    step(1'b0, 1'b1, F_EOF);
    stat(4'h4, 8'h02);
    wr(cmosit_pkg::ADDR_PAGE, 8'hf0);
    rdc(cmosit_pkg::ADDR_PAGE, 8'hf0);
    rdc(cmosit_pkg::ADDR_STATUS, 8'h00);
    rdc(8'hbc, 8'h00);
    end_sim;
  end
endmodule
bind cmosit_msg_obj cmosit_msg_obj_sva sva (.sys_clk(sys_clk), .rst_b(rst_b), .sfr(sfr), .sfrRdData(sfrRdData),
  .canRxPin(canRxPin), .bitTick(bitTick), .field(field), .evt(evt), .rxBitSync(rxBitSync), .txReq(txReq),
  .rxTarget(rxTarget), .objIrq(objIrq));
`default_nettype wire

/* verilog/cmosit_bit_check.sv */
// per-bit error detection on the sampled bus level: stuff, crc, form, ack and bit errors
// assumes the rx level is already synchronised and field markers arrive with bitTick
`timescale 1ns/1ps
`default_nettype none
module cmosit_bit_check (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // bit stream
  input wire logic bitTick,
  input wire logic rxBit,
  input wire logic txBit,
  input wire cmosit_pkg::cmosit_field_type field,
  // detected errors, one-cycle pulses
  output cmosit_pkg::cmosit_err_type errPulse
);
  logic lastBit;
  logic [2:0] sameCount;
  logic [14:0] crcCalc;
  logic [14:0] crcRecv;
  logic [2:0] baseCount;
  logic [14:0] baseCrc;
  logic stuffBit;
  logic crcFeed;

  // a new frame starts its run and crc from scratch on the start bit itself
  assign baseCount = field.frameStart ? cmosit_pkg::RUN_CLEAR : sameCount;
  assign baseCrc = field.frameStart ? cmosit_pkg::CRC_INIT : crcCalc;
  assign stuffBit = field.stuffRegion && (baseCount == cmosit_pkg::STUFF_LIMIT) && (rxBit != lastBit);
  assign crcFeed = rxBit ^ baseCrc[cmosit_pkg::CRC_WIDTH-1];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lastBit <= 1'b1;
      sameCount <= 3'h0;
    end else if (bitTick) begin
      lastBit <= rxBit;
      if (!field.stuffRegion) begin
        sameCount <= cmosit_pkg::RUN_CLEAR;
      end else if (baseCount != cmosit_pkg::RUN_CLEAR && rxBit == lastBit) begin
        sameCount <= 3'(baseCount + 3'h1);
      end else begin
        sameCount <= cmosit_pkg::RUN_START;
      end
    end
  end

  // stuff bits are dropped before the crc sees the stream
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      crcCalc <= 15'h0000;
    end else if (bitTick && field.crcRegion && !stuffBit) begin
      crcCalc <= {baseCrc[13:0], 1'b0} ^ (crcFeed ? cmosit_pkg::CRC_POLY : cmosit_pkg::CRC_INIT);
    end else if (bitTick && field.frameStart) begin
      crcCalc <= cmosit_pkg::CRC_INIT;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      crcRecv <= 15'h0000;
    end else if (bitTick && field.crcField && !stuffBit) begin
      crcRecv <= {crcRecv[13:0], rxBit};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      errPulse <= '0;
    end else begin
      errPulse <= '0;
      if (bitTick) begin
        // sixth equal bit in a row
        errPulse.stuffErr <= field.stuffRegion && (baseCount == cmosit_pkg::STUFF_LIMIT)
                             && (rxBit == lastBit);
        errPulse.crcErr <= field.crcDelim && (crcRecv != crcCalc);
        errPulse.formErr <= (field.crcDelim || field.ackDelim || field.eofField) && !rxBit;
        errPulse.ackErr <= field.txActive && field.ackSlot && rxBit;
        // lost arbitration and a dominant ack are expected mismatches
        errPulse.bitErr <= field.txActive && (rxBit != txBit)
                           && !(field.arbField && txBit && !rxBit)
                           && !(field.ackSlot && !rxBit);
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/cmosit_msg_obj.sv */
// message object status, control and identifier tag registers with transmit and receive arbitration
// Behaviour
// - set length warning on mismatch, always store received length
// - set transmit complete when object's transmission finishes
// - lowest index transmit object is sent first
// - set receive complete when object's reception finishes
// - only lowest index matching receive object updated
// - bit error on readback mismatch while transmitting
// - stuff error after more than five equal bits
// - crc over destuffed frame compared to crc field
// - form error on delimiters or end of frame
// - ack error without dominant ack when sending
// - transmit, receive and error flags request interrupts
// - standard layout identifier bits in first two tags
// - standard fourth tag holds remote and reserved-zero
// - extended layout spreads 29 bits over four tags
// - tag registers sit at four consecutive addresses
// - extension flag picks standard or extended layout
// - page object number selects accessed object
// assumes a frame sequencer on the same clock drives bitTick, field markers and events;
// the rx pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`default_nettype none
module cmosit_msg_obj (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // special function register bus
  input wire cmosit_pkg::cmosit_sfr_type sfr,
  output logic [7:0] sfrRdData,
  // bus pin and frame sequencer
  input wire logic canRxPin,
  input wire logic bitTick,
  input wire logic txBit,
  input wire cmosit_pkg::cmosit_field_type field,
  input wire cmosit_pkg::cmosit_evt_type evt,
  output logic rxBitSync,
  // selected transmit object
  output logic txReq,
  output logic [3:0] txObject,
  output logic [28:0] txIdentifier,
  output logic txIde,
  output logic txRtr,
  output logic [3:0] txDlc,
  // receive target and interrupt requests
  output logic [3:0] rxTarget,
  output logic [cmosit_pkg::OBJ_COUNT-1:0] objIrq
);
  logic rxMeta;
  logic rxSync;
  logic [7:0] pageReg;
  logic [7:0] statusReg [cmosit_pkg::OBJ_COUNT];
  logic [7:0] ctrlReg [cmosit_pkg::OBJ_COUNT];
  logic [7:0] tagReg [cmosit_pkg::OBJ_COUNT][4];
  logic [7:0] setBits [cmosit_pkg::OBJ_COUNT];
  logic [3:0] selObj;
  logic selValid;
  logic [3:0] next_txObject;
  logic next_txReq;
  logic [3:0] rxWinner;
  logic rxAny;
  logic [3:0] activeTx;
  logic [3:0] errObj;
  logic [7:0] next_rdData;
  logic [28:0] next_txId;
  logic selExt;
  logic activeValid;
  logic statusWr;
  logic ctrlWr;
  logic tagWr;
  cmosit_pkg::cmosit_err_type errPulse;

  // two-stage synchroniser for the bus level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= canRxPin;
      rxSync <= rxMeta;
    end
  end

  assign rxBitSync = rxSync;

  cmosit_bit_check u_bit_check (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bitTick(bitTick),
    .rxBit(rxSync),
    .txBit(txBit),
    .field(field),
    .errPulse(errPulse)
  );

  // page select; object numbers above the last one reach nothing
  assign selObj = pageReg[cmosit_pkg::PAGE_OBJ_MSB:cmosit_pkg::PAGE_OBJ_LSB];
  assign selValid = selObj <= cmosit_pkg::OBJ_LAST;
  assign selExt = ctrlReg[selObj][cmosit_pkg::CTRL_IDE_BIT];
  assign statusWr = sfr.wrEn && selValid && sfr.addr == cmosit_pkg::ADDR_STATUS;
  assign ctrlWr = sfr.wrEn && selValid && sfr.addr == cmosit_pkg::ADDR_CTRL;
  assign tagWr = sfr.wrEn && selValid && sfr.addr >= cmosit_pkg::ADDR_TAG1 && sfr.addr <= cmosit_pkg::ADDR_TAG4;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pageReg <= cmosit_pkg::PAGE_RESET;
    end else if (sfr.wrEn && sfr.addr == cmosit_pkg::ADDR_PAGE) begin
      pageReg <= sfr.wrData;
    end
  end

  // lowest enabled transmit object wins
  always_comb begin
    next_txReq = 1'b0;
    next_txObject = 4'h0;
    for (int i = cmosit_pkg::OBJ_COUNT - 1; i >= 0; i--) begin
      if (ctrlReg[i][cmosit_pkg::CTRL_CONF_MSB:cmosit_pkg::CTRL_CONF_LSB] == cmosit_pkg::CONF_TX) begin
        next_txReq = 1'b1;
        next_txObject = 4'(i);
      end
    end
  end

  // lowest matching receive object wins
  always_comb begin
    rxAny = 1'b0;
    rxWinner = 4'h0;
    for (int i = cmosit_pkg::OBJ_COUNT - 1; i >= 0; i--) begin
      if (evt.rxHit[i]) begin
        rxAny = 1'b1;
        rxWinner = 4'(i);
      end
    end
  end

  // the transmit object is frozen for the frame so errors land on the sender
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      activeTx <= 4'h0;
    end else if (bitTick && field.frameStart) begin
      activeTx <= next_txObject;
    end
  end

  // a frame with no transmit object pending must not charge object zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      activeValid <= 1'b0;
    end else if (bitTick && field.frameStart) begin
      activeValid <= next_txReq;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxTarget <= 4'h0;
    end else if (rxAny) begin
      rxTarget <= rxWinner;
    end
  end

  // errors go to the sender while transmitting, else to the last receive target
  assign errObj = field.txActive ? activeTx : rxTarget;

  // hardware set requests per object
  always_comb begin
    for (int i = 0; i < cmosit_pkg::OBJ_COUNT; i++) begin
      setBits[i] = 8'h00;
      if (evt.txDone && activeValid && activeTx == 4'(i)) begin
        setBits[i][cmosit_pkg::ST_TX_DONE] = 1'b1;
      end
      if (evt.rxDone && rxAny && rxWinner == 4'(i)) begin
        setBits[i][cmosit_pkg::ST_RX_DONE] = 1'b1;
        setBits[i][cmosit_pkg::ST_LEN_WARN] =
          evt.rxDlc != ctrlReg[i][cmosit_pkg::CTRL_DLC_MSB:0];
      end
      if (errObj == 4'(i)) begin
        setBits[i][cmosit_pkg::ST_BIT_ERR] = errPulse.bitErr;
        setBits[i][cmosit_pkg::ST_STUFF_ERR] = errPulse.stuffErr;
        setBits[i][cmosit_pkg::ST_CRC_ERR] = errPulse.crcErr;
        setBits[i][cmosit_pkg::ST_FORM_ERR] = errPulse.formErr;
        setBits[i][cmosit_pkg::ST_ACK_ERR] = errPulse.ackErr;
      end
    end
  end

  // a write can only clear; a same-cycle event still lands
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < cmosit_pkg::OBJ_COUNT; i++) begin
        statusReg[i] <= cmosit_pkg::STATUS_RESET;
      end
    end else begin
      for (int i = 0; i < cmosit_pkg::OBJ_COUNT; i++) begin
        if (statusWr && selObj == 4'(i)) begin
          statusReg[i] <= (statusReg[i] & sfr.wrData) | setBits[i];
        end else begin
          statusReg[i] <= statusReg[i] | setBits[i];
        end
      end
    end
  end

  // control: software write, then hardware length update and transmit retire
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < cmosit_pkg::OBJ_COUNT; i++) begin
        ctrlReg[i] <= cmosit_pkg::CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < cmosit_pkg::OBJ_COUNT; i++) begin
        if (ctrlWr && selObj == 4'(i)) begin
          ctrlReg[i] <= sfr.wrData;
        end
        if (evt.rxDone && rxAny && rxWinner == 4'(i)) begin
          ctrlReg[i][cmosit_pkg::CTRL_DLC_MSB:0] <= evt.rxDlc;
        end
        // retire a finished transmission so the next object can go
        if (evt.txDone && activeValid && activeTx == 4'(i)) begin
          ctrlReg[i][cmosit_pkg::CTRL_CONF_MSB:cmosit_pkg::CTRL_CONF_LSB] <= cmosit_pkg::CONF_DISABLE;
        end
      end
    end
  end

  // tags hold what software wrote; layout only matters on read and on use
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < cmosit_pkg::OBJ_COUNT; i++) begin
        for (int j = 0; j < 4; j++) begin
          tagReg[i][j] <= cmosit_pkg::TAG_RESET;
        end
      end
    end else if (tagWr) begin
      tagReg[selObj][2'(sfr.addr - cmosit_pkg::ADDR_TAG1)] <= sfr.wrData;
    end
  end

  // register read, one cycle after the read strobe
  always_comb begin
    next_rdData = cmosit_pkg::READ_ZERO;
    if (sfr.addr == cmosit_pkg::ADDR_PAGE) begin
      next_rdData = pageReg;
    end else if (selValid) begin
      unique case (sfr.addr)
        cmosit_pkg::ADDR_STATUS: next_rdData = statusReg[selObj];
        cmosit_pkg::ADDR_CTRL: next_rdData = ctrlReg[selObj];
        cmosit_pkg::ADDR_TAG1: next_rdData = tagReg[selObj][0];
        cmosit_pkg::ADDR_TAG2: begin
          next_rdData = selExt ? tagReg[selObj][1]
                               : (tagReg[selObj][1] & cmosit_pkg::STD_ID_LOW_MASK);
        end
        cmosit_pkg::ADDR_TAG3: next_rdData = selExt ? tagReg[selObj][2] : cmosit_pkg::READ_ZERO;
        cmosit_pkg::ADDR_TAG4: begin
          next_rdData = selExt ? tagReg[selObj][3]
                               : (tagReg[selObj][3] & cmosit_pkg::STD_FLAGS_MASK);
        end
        default: next_rdData = cmosit_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfrRdData <= cmosit_pkg::READ_ZERO;
    end else if (sfr.rdEn) begin
      sfrRdData <= next_rdData;
    end
  end

  // identifier of the winning transmit object in its own layout
  always_comb begin
    if (ctrlReg[next_txObject][cmosit_pkg::CTRL_IDE_BIT]) begin
      next_txId = {tagReg[next_txObject][0], tagReg[next_txObject][1],
                   tagReg[next_txObject][2], tagReg[next_txObject][3][7:3]};
    end else begin
      next_txId = {18'h00000, tagReg[next_txObject][0], tagReg[next_txObject][1][7:5]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txReq <= 1'b0;
    end else begin
      txReq <= next_txReq;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txObject <= 4'h0;
    end else begin
      txObject <= next_txObject;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txIdentifier <= 29'h00000000;
    end else begin
      txIdentifier <= next_txId;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txIde <= 1'b0;
    end else begin
      txIde <= ctrlReg[next_txObject][cmosit_pkg::CTRL_IDE_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txRtr <= 1'b0;
    end else begin
      txRtr <= tagReg[next_txObject][3][cmosit_pkg::TAG_RTR_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txDlc <= 4'h0;
    end else begin
      txDlc <= ctrlReg[next_txObject][cmosit_pkg::CTRL_DLC_MSB:0];
    end
  end

  // any completion or error flag raises the object's request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      objIrq <= '0;
    end else begin
      for (int i = 0; i < cmosit_pkg::OBJ_COUNT; i++) begin
        objIrq[i] <= |statusReg[i][cmosit_pkg::ST_IRQ_MSB:0];
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/cmosit_pkg.sv */
// shared constants and carrier types for the message object status and identifier tag block
// assumes one controller clock and an 8-bit special function register bus
package cmosit_pkg;
  localparam int OBJ_COUNT = 15;
  localparam logic [3:0] OBJ_LAST = 4'he;

  // special function register addresses
  localparam logic [7:0] ADDR_PAGE = 8'hb1;
  localparam logic [7:0] ADDR_STATUS = 8'hb2;
  localparam logic [7:0] ADDR_CTRL = 8'hb3;
  localparam logic [7:0] ADDR_TAG1 = 8'hbc;
  localparam logic [7:0] ADDR_TAG2 = 8'hbd;
  localparam logic [7:0] ADDR_TAG3 = 8'hbe;
  localparam logic [7:0] ADDR_TAG4 = 8'hbf;

  // reset values
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TAG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // status bit positions
  localparam int ST_LEN_WARN = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_RX_DONE = 5;
  localparam int ST_BIT_ERR = 4;
  localparam int ST_STUFF_ERR = 3;
  localparam int ST_CRC_ERR = 2;
  localparam int ST_FORM_ERR = 1;
  localparam int ST_ACK_ERR = 0;
  localparam int ST_IRQ_MSB = 6;

  // page and control fields
  localparam int PAGE_OBJ_MSB = 7;
  localparam int PAGE_OBJ_LSB = 4;
  localparam int CTRL_CONF_MSB = 7;
  localparam int CTRL_CONF_LSB = 6;
  localparam int CTRL_IDE_BIT = 4;
  localparam int CTRL_DLC_MSB = 3;
  localparam logic [1:0] CONF_DISABLE = 2'h0;
  localparam logic [1:0] CONF_TX = 2'h1;

  // tag byte layout
  localparam logic [7:0] STD_ID_LOW_MASK = 8'he0;
  localparam logic [7:0] STD_FLAGS_MASK = 8'h05;
  localparam int TAG_RTR_BIT = 2;
  localparam int TAG_RB1_BIT = 1;
  localparam int TAG_RB0_BIT = 0;

  // bit stream checks
  localparam int CRC_WIDTH = 15;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [14:0] CRC_INIT = 15'h0000;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [2:0] RUN_START = 3'h1;
  localparam logic [2:0] RUN_CLEAR = 3'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrEn;
    logic rdEn;
  } cmosit_sfr_type;

  // field markers from the frame sequencer, valid with the bit tick
  typedef struct packed {
    logic txActive;
    logic arbField;
    logic ackSlot;
    logic errFrame;
    logic stuffRegion;
    logic crcRegion;
    logic crcField;
    logic crcDelim;
    logic ackDelim;
    logic eofField;
    logic frameStart;
  } cmosit_field_type;

  typedef struct packed {
    logic bitErr;
    logic stuffErr;
    logic crcErr;
    logic formErr;
    logic ackErr;
  } cmosit_err_type;

  typedef struct packed {
    logic txDone;
    logic rxDone;
    logic [3:0] rxDlc;
    logic [OBJ_COUNT-1:0] rxHit;
  } cmosit_evt_type;
endpackage
